// >>> hdl/bit_flag_shift_pkg.sv
// Functional notes
// (RULE1) Toggle op: byte XOR into memory, two cycles.
// (RULE2) Rotate left through carry, flags, one cycle.
// (RULE3) Rotate right through carry, flags, one cycle.
// (RULE4) I/O bit set, one cycle, flags kept.
// (RULE5) I/O bit clear, one cycle, flags kept.
// (RULE6) Register bit copied into transfer flag.
// (RULE7) Transfer flag copied into register bit.
// (RULE8) Set overflow flag only, one cycle.
// (RULE9) Clear overflow flag only, one cycle.
// (RULE10) Set half carry flag only, one cycle.
// (RULE11) Clear half carry flag only, one cycle.
// (RULE12) Set sign test flag only, one cycle.
// (RULE13) Clear sign test flag only, one cycle.
// (RULE14) Cycle counts hold for internal memory only.
// (RULE15) Internal SRAM access adds one cycle.
// (RULE16) Logical, arithmetic shifts and nibble swap.
// (RULE17) Other flag ops and control ops: one cycle.
package bit_flag_shift_pkg;

  // Register byte offsets on the APB bus.
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFF_CMD       = 8'h00;
  localparam logic [7:0] OFF_OPERAND   = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_ZPTR      = 8'h0C;
  localparam logic [7:0] OFF_MEM_DATA  = 8'h10;
  localparam logic [7:0] OFF_IO_ADDR   = 8'h14;
  localparam logic [7:0] OFF_IO_DATA   = 8'h18;
  localparam logic [7:0] OFF_EXEC_STAT = 8'h1C;

  // Bit positions of the status word flags.
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // Reset values.
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  OPERAND_RESET = 8'h00;
  localparam logic [15:0] ZPTR_RESET    = 16'h0000;

  // Cycle counts of the executed operations.
  localparam logic [3:0] CYC_SINGLE      = 4'h1;
  localparam logic [3:0] CYC_TOGGLE_BASE = 4'h2;
  localparam logic [3:0] CYC_SRAM_EXTRA  = 4'h1;

  // Operation codes written to the command register.
  typedef enum logic [4:0] {
    OP_NOP, OP_TOGGLE_RAM, OP_SHL_LOG, OP_SHR_LOG, OP_ROT_LEFT,
    OP_ROT_RIGHT, OP_SHR_ARITH, OP_SWAP, OP_IO_SET, OP_IO_CLR,
    OP_TO_TBIT, OP_FROM_TBIT, OP_FLAG_SET, OP_FLAG_CLR, OP_SET_OVF,
    OP_CLR_OVF, OP_SET_HALF, OP_CLR_HALF, OP_SET_SIGN, OP_CLR_SIGN,
    OP_BREAK, OP_SLEEP, OP_WDR
  } op_e;

  // Command register layout: bit select above the operation code.
  typedef struct packed {
    logic [2:0] bit_sel;
    op_e        op;
  } cmd_s;

  // Result of one shift unit pass: new operand and new status word.
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] sw;
  } shift_s;

endpackage

// >>> hdl/bit_flag_shift_ops.sv
`timescale 1ns/1ps
`default_nettype none
module bit_flag_shift_ops #(
  parameter int unsigned MEM_DEPTH = 256,
  parameter int unsigned IO_DEPTH  = 32
) (
  input  wire logic                                  MCLK_I,
  input  wire logic                                  RESET_I,
  input  wire logic                                  CE_I,
  input  wire logic                                  PSEL_I,
  input  wire logic                                  PENABLE_I,
  input  wire logic                                  PWRITE_I,
  input  wire logic [bit_flag_shift_pkg::APB_AW-1:0] PADDR_I,
  input  wire logic [31:0]                           PWDATA_I,
  output var  logic [31:0]                           PRDATA_O,
  output var  logic                                  PREADY_O,
  output var  logic                                  PSLVERR_O,
  output var  logic                                  BUSY_O,
  output var  logic                                  BREAK_O,
  output var  logic                                  SLEEP_O,
  output var  logic                                  WDT_CLEAR_O
);
  import bit_flag_shift_pkg::*;

  localparam int unsigned MEM_AW = $clog2(MEM_DEPTH);
  localparam int unsigned IO_AW  = $clog2(IO_DEPTH);

  // Refuse sizes that the 16-bit pointer and 8-bit fields cannot address.
  if (MEM_DEPTH < 2 || MEM_DEPTH > 65536 || (1 << MEM_AW) != MEM_DEPTH)
    $error("MEM_DEPTH must be a power of two from 2 to 65536.");
  if (IO_DEPTH < 2 || IO_DEPTH > 256 || (1 << IO_AW) != IO_DEPTH)
    $error("IO_DEPTH must be a power of two from 2 to 256.");

  typedef enum {ST_IDLE, ST_EXEC} core_e;

  // True for every word offset that holds a register.
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    is_mapped = (a == OFF_CMD) || (a == OFF_OPERAND) ||
                (a == OFF_STATUS) || (a == OFF_ZPTR) ||
                (a == OFF_MEM_DATA) || (a == OFF_IO_ADDR) ||
                (a == OFF_IO_DATA) || (a == OFF_EXEC_STAT);
  endfunction

  // Shift and rotate unit; flags follow the usual arithmetic rules.
  function automatic shift_s shift_exec(input op_e op,
                                        input logic [7:0] a,
                                        input logic [7:0] sw);
    shift_s     o;
    logic       cout;
    o.sw = sw;
    cout = a[0];
    case (op)
      OP_SHL_LOG:
      begin
        o.res = {a[6:0], 1'b0};                     // RULE16
        cout  = a[7];
      end
      OP_ROT_LEFT:
      begin
        o.res = {a[6:0], sw[FLAG_C]};               // RULE2
        cout  = a[7];
      end
      OP_SHR_LOG:   o.res = {1'b0, a[7:1]};         // RULE16
      OP_ROT_RIGHT: o.res = {sw[FLAG_C], a[7:1]};   // RULE3
      OP_SHR_ARITH: o.res = {a[7], a[7:1]};         // RULE16
      default: o.res = a;
    endcase
    // Only the left moves touch half carry; it takes old bit 3.
    if (op == OP_SHL_LOG || op == OP_ROT_LEFT)
      o.sw[FLAG_H] = a[3];                          // RULE2
    o.sw[FLAG_C] = cout;
    o.sw[FLAG_Z] = (o.res == 8'h00);
    o.sw[FLAG_N] = o.res[7];
    o.sw[FLAG_V] = o.res[7] ^ cout;                 // RULE3
    o.sw[FLAG_S] = o.res[7] ^ o.sw[FLAG_V];
    return o;
  endfunction

  // Bus answer registers.
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        wr_fire;            // An accepted write, not a refused one, commits at this edge.

  // Core state.
  core_e         state_q, state_d;
  cmd_s          cmd_q, cmd_d;     // Command under execution.
  logic [3:0]    cnt_q, cnt_d;     // Cycles left in execution.
  logic [3:0]    last_q, last_d;   // Cycle count of the latest command.
  logic [7:0]    opnd_q, opnd_d;   // Working register.
  logic [7:0]    sw_q, sw_d;       // Status word.
  logic [15:0]   zptr_q, zptr_d;   // Pointer into data memory.
  logic [7:0]    ioa_q, ioa_d;     // I/O register address.
  logic          busy_q, busy_d;
  logic          brk_q, brk_d;
  logic          slp_q, slp_d;
  logic          wdr_q, wdr_d;

  // Internal data memory and I/O register space.
  logic [7:0]        mem_q [MEM_DEPTH];
  logic [7:0]        io_q  [IO_DEPTH];
  logic              mem_we, io_we;
  logic [7:0]        mem_wdata, io_wdata;
  logic [MEM_AW-1:0] mem_idx;
  logic [IO_AW-1:0]  io_idx;
  logic [7:0]        mem_rd, io_rd;
  shift_s            sh;

  assign mem_idx = zptr_q[MEM_AW-1:0];
  assign io_idx  = ioa_q[IO_AW-1:0];
  assign mem_rd  = mem_q[mem_idx];
  assign io_rd   = io_q[io_idx];
  assign sh      = shift_exec(cmd_q.op, opnd_q, sw_q);
  assign wr_fire = PSEL_I & PENABLE_I & pready_q & PWRITE_I & ~pslverr_q;

  // Bus answer: one wait state, then ready with data and error.
  // Writes while busy are refused so memory stays stable during a
  // multi-cycle command.
  always_comb
  begin
    pready_d  = PSEL_I & PENABLE_I & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (pready_d)
    begin
      pslverr_d = ~is_mapped(PADDR_I) | (PWRITE_I & busy_q);
      case (PADDR_I)
        OFF_CMD:       prdata_d[7:0] = cmd_q;
        OFF_OPERAND:   prdata_d[7:0] = opnd_q;
        OFF_STATUS:    prdata_d[7:0] = sw_q;
        OFF_ZPTR:      prdata_d[15:0] = zptr_q;
        OFF_MEM_DATA:  prdata_d[7:0] = mem_rd;
        OFF_IO_ADDR:   prdata_d[7:0] = ioa_q;
        OFF_IO_DATA:   prdata_d[7:0] = io_rd;
        OFF_EXEC_STAT: prdata_d[4:0] = {busy_q, last_q};
        default:       prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer registers.
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else if (CE_I)
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Core next state: register writes, command start and commit.
  always_comb
  begin
    state_d   = state_q;
    cmd_d     = cmd_q;
    cnt_d     = cnt_q;
    last_d    = last_q;
    opnd_d    = opnd_q;
    sw_d      = sw_q;
    zptr_d    = zptr_q;
    ioa_d     = ioa_q;
    brk_d     = 1'b0;
    slp_d     = 1'b0;
    wdr_d     = 1'b0;
    mem_we    = 1'b0;
    mem_wdata = 8'h00;
    io_we     = 1'b0;
    io_wdata  = 8'h00;
    if (wr_fire)
    begin
      case (PADDR_I)
        OFF_CMD:
        begin
          cmd_d   = cmd_s'(PWDATA_I[7:0]);
          state_d = ST_EXEC;
          // Only the toggle op touches memory; it is internal SRAM,
          // so its base count gains the extra cycle.
          if (cmd_d.op == OP_TOGGLE_RAM)
            cnt_d = CYC_TOGGLE_BASE + CYC_SRAM_EXTRA; // RULE14 RULE15
          else
            cnt_d = CYC_SINGLE;                     // RULE17
          last_d = cnt_d;
        end
        OFF_OPERAND: opnd_d = PWDATA_I[7:0];
        OFF_STATUS:  sw_d   = PWDATA_I[7:0];
        OFF_ZPTR:    zptr_d = PWDATA_I[15:0];
        OFF_MEM_DATA:
        begin
          mem_we    = 1'b1;
          mem_wdata = PWDATA_I[7:0];
        end
        OFF_IO_ADDR: ioa_d = PWDATA_I[7:0];
        OFF_IO_DATA:
        begin
          io_we    = 1'b1;
          io_wdata = PWDATA_I[7:0];
        end
        default: ;                                  // Execution status is read-only.
      endcase
    end
    else if (state_q == ST_EXEC)
    begin
      cnt_d = cnt_q - 4'h1;
      if (cnt_q == 4'h1)
      begin
        state_d = ST_IDLE;
        case (cmd_q.op)
          OP_TOGGLE_RAM:
          begin
            opnd_d    = mem_rd;                     // RULE1
            mem_we    = 1'b1;
            mem_wdata = opnd_q ^ mem_rd;            // RULE1
          end
          OP_SHL_LOG, OP_SHR_LOG, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHR_ARITH:
          begin
            opnd_d = sh.res;                        // RULE2 RULE3 RULE16
            sw_d   = sh.sw;
          end
          OP_SWAP: opnd_d = {opnd_q[3:0], opnd_q[7:4]}; // RULE16
          OP_IO_SET:
          begin
            io_we    = 1'b1;
            io_wdata = io_rd | (8'h01 << cmd_q.bit_sel); // RULE4
          end
          OP_IO_CLR:
          begin
            io_we    = 1'b1;
            io_wdata = io_rd & ~(8'h01 << cmd_q.bit_sel); // RULE5
          end
          OP_TO_TBIT: sw_d[FLAG_T] = opnd_q[cmd_q.bit_sel];   // RULE6
          OP_FROM_TBIT: opnd_d[cmd_q.bit_sel] = sw_q[FLAG_T]; // RULE7
          OP_FLAG_SET: sw_d[cmd_q.bit_sel] = 1'b1;       // RULE17
          OP_FLAG_CLR: sw_d[cmd_q.bit_sel] = 1'b0;       // RULE17
          OP_SET_OVF:  sw_d[FLAG_V] = 1'b1;         // RULE8
          OP_CLR_OVF:  sw_d[FLAG_V] = 1'b0;         // RULE9
          OP_SET_HALF: sw_d[FLAG_H] = 1'b1;         // RULE10
          OP_CLR_HALF: sw_d[FLAG_H] = 1'b0;         // RULE11
          OP_SET_SIGN: sw_d[FLAG_S] = 1'b1;         // RULE12
          OP_CLR_SIGN: sw_d[FLAG_S] = 1'b0;         // RULE13
          OP_BREAK: brk_d = 1'b1;                   // RULE17
          OP_SLEEP: slp_d = 1'b1;                   // RULE17
          OP_WDR:   wdr_d = 1'b1;                   // RULE17
          default: ;                                // No-op and unknown.
        endcase
      end
    end
    busy_d = (state_d == ST_EXEC);
  end

  // Core registers; the arrays hold no reset, like real SRAM.
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      state_q <= ST_IDLE;
      cmd_q   <= cmd_s'(8'h00);
      cnt_q   <= 4'h0;
      last_q  <= 4'h0;
      opnd_q  <= OPERAND_RESET;
      sw_q    <= STATUS_RESET;
      zptr_q  <= ZPTR_RESET;
      ioa_q   <= 8'h00;
      busy_q  <= 1'b0;
      brk_q   <= 1'b0;
      slp_q   <= 1'b0;
      wdr_q   <= 1'b0;
    end
    else if (CE_I)
    begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      cnt_q   <= cnt_d;
      last_q  <= last_d;
      opnd_q  <= opnd_d;
      sw_q    <= sw_d;
      zptr_q  <= zptr_d;
      ioa_q   <= ioa_d;
      busy_q  <= busy_d;
      brk_q   <= brk_d;
      slp_q   <= slp_d;
      wdr_q   <= wdr_d;
    end
  end

  // Memory and I/O space writes.
  always_ff @(posedge MCLK_I)
  begin
    if (CE_I && !RESET_I)
    begin
      if (mem_we)
        mem_q[mem_idx] <= mem_wdata;
      if (io_we)
        io_q[io_idx] <= io_wdata;
    end
  end

  assign PRDATA_O    = prdata_q;
  assign PREADY_O    = pready_q;
  assign PSLVERR_O   = pslverr_q;
  assign BUSY_O      = busy_q;
  assign BREAK_O     = brk_q;
  assign SLEEP_O     = slp_q;
  assign WDT_CLEAR_O = wdr_q;

endmodule // bit_flag_shift_ops
`default_nettype wire

// >>> sim/bit_flag_shift_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bit_flag_shift_chk (
  input wire logic        MCLK_I,
  input wire logic        RESET_I,
  input wire logic        CE_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        BUSY_O,
  input wire logic        BREAK_O,
  input wire logic        SLEEP_O,
  input wire logic        WDT_CLEAR_O
);
  logic       cmd_w; // A command write commits at this edge.
  logic [4:0] opc;   // Operation code carried by that write.
  // Only accepted writes start a command, refused ones must not.
  assign cmd_w = PSEL_I && PENABLE_I && PREADY_O && !PSLVERR_O
    && PWRITE_I && PADDR_I == 8'h00 && CE_I;
  assign opc = PWDATA_I[4:0];
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  a_toggle_len: assert property (cmd_w && opc == 5'h01
    |=> BUSY_O [*3] ##1 !BUSY_O) else $error("toggle length wrong");
  a_single_len: assert property (cmd_w && opc != 5'h01
    |=> BUSY_O ##1 !BUSY_O) else $error("single op length wrong");
  a_break_pulse: assert property (cmd_w && opc == 5'h14
    |=> !BREAK_O ##1 BREAK_O ##1 !BREAK_O) else $error("break pulse");
  a_sleep_pulse: assert property (cmd_w && opc == 5'h15
    |=> !SLEEP_O ##1 SLEEP_O ##1 !SLEEP_O) else $error("sleep pulse");
  a_wdr_pulse: assert property (cmd_w && opc == 5'h16
    |=> !WDT_CLEAR_O ##1 WDT_CLEAR_O) else $error("watchdog pulse");
  a_stray_pulse: assert property (BREAK_O || SLEEP_O || WDT_CLEAR_O
    |-> $past(BUSY_O) && !BUSY_O) else $error("pulse off commit");
  a_ready_wait: assert property ($rose(PENABLE_I) && PSEL_I
    |-> !PREADY_O ##1 PREADY_O) else $error("wait state wrong");
  a_unmapped_err: assert property (PREADY_O && PADDR_I > 8'h1C
    |-> PSLVERR_O && PRDATA_O == 32'h0) else $error("unmapped answer");
  a_busy_refuse: assert property (PSEL_I && PENABLE_I && PREADY_O
    && PWRITE_I && BUSY_O |-> PSLVERR_O) else $error("busy write taken");
endmodule // bit_flag_shift_chk
bind bit_flag_shift_ops bit_flag_shift_chk bit_flag_shift_chk_i (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .BUSY_O(BUSY_O), .BREAK_O(BREAK_O),
  .SLEEP_O(SLEEP_O), .WDT_CLEAR_O(WDT_CLEAR_O));
`default_nettype wire

// >>> sim/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output var  logic        psel_o,
  output var  logic        penable_o,
  output var  logic        pwrite_o,
  output var  logic [7:0]  paddr_o,
  output var  logic [31:0] pwdata_o
);
  logic held; // A back-to-back setup may start without an idle edge.
  // The bus idles low from time zero.
  initial
  begin
    held = 1'b0;
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  end
  // One transfer; the request stands until ready is seen at an edge.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic more,
                      output logic [31:0] q, output logic e);
    if (!held)
    begin
      @(posedge clk_i);
      psel_o <= 1'b1;
    end
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // No wait length is assumed; only the bench watchdog ends a hang.
    @(posedge clk_i);
    while (pready_i !== 1'b1)
      @(posedge clk_i);
    // Data and response are taken at the edge where ready is seen.
    q = prdata_i;
    e = pslverr_i;
    penable_o <= 1'b0;
    if (!more) psel_o <= 1'b0;
    held = more;
  endtask
endmodule // apb_host_model
`default_nettype wire

// >>> sim/bit_flag_shift_ops_test.sv
`timescale 1ns/1ps
`default_nettype none
module bit_flag_shift_ops_test;
  import bit_flag_shift_pkg::*;
  logic        clk, rst, psel, pen, pwr, rdy, serr, busy;
  logic        brk, slp, wdc;
  logic [7:0]  addr;
  logic [31:0] wdat, rdat, q;
  logic        e;
  logic [15:0] x;
  int          err_count, checks, idx;
  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  bit_flag_shift_ops bit_flag_shift_ops_i (.MCLK_I(clk), .RESET_I(rst),
    .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(addr), .PWDATA_I(wdat), .PRDATA_O(rdat), .PREADY_O(rdy),
    .PSLVERR_O(serr), .BUSY_O(busy), .BREAK_O(brk), .SLEEP_O(slp),
    .WDT_CLEAR_O(wdc));
  apb_host_model apb_host_model_i (.clk_i(clk), .prdata_i(rdat),
    .pready_i(rdy), .pslverr_i(serr), .psel_o(psel), .penable_o(pen),
    .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wdat));
  // Counts every comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_host_model_i.xfer(1'b1, a, d, 1'b0, q, e);
    check(e, 0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb_host_model_i.xfer(1'b0, a, 32'h0, 1'b0, q, e);
    check(q, exp);
  endtask
  // Issues a command, then waits a bounded time for busy to drop.
  task automatic cmd(input logic [4:0] op, input logic [2:0] b);
    wr(OFF_CMD, {24'h0, b, op});
    @(posedge clk);
    for (int n = 0; n < 8 && busy !== 1'b0; n++) @(posedge clk);
  endtask
  // Reference shift unit: result in the upper byte, flags below.
  function automatic logic [15:0] shx(input logic [4:0] op,
                                      input logic [7:0] a,
                                      input logic [7:0] s);
    logic [7:0] r;
    logic       c;
    case (op)
      5'h02: {c, r} = {a, 1'b0};
      5'h03: {r, c} = {1'b0, a};
      5'h04: {c, r} = {a, s[FLAG_C]};
      5'h05: {r, c} = {s[FLAG_C], a};
      5'h06: {r, c} = {a[7], a};
      default: return {a[3:0], a[7:4], s};
    endcase
    s[FLAG_C] = c;
    s[FLAG_Z] = (r == 8'h00);
    s[FLAG_N] = r[7];
    s[FLAG_V] = r[7] ^ c;
    s[FLAG_S] = s[FLAG_N] ^ s[FLAG_V];
    if (op == 5'h02 || op == 5'h04) s[FLAG_H] = a[3];
    return {r, s};
  endfunction
  task automatic t_reset();
    rd(OFF_STATUS, 0);
    rd(OFF_ZPTR, 0);
    rd(OFF_OPERAND, 0);
    rd(OFF_IO_ADDR, 0);
    rd(OFF_EXEC_STAT, 0);
    rd(8'h20, 0);
    check(e, 1);
  endtask
  // Toggle, with a write refused while it runs.
  task automatic t_toggle();
    wr(OFF_ZPTR, 5);
    wr(OFF_MEM_DATA, 8'h3C);
    wr(OFF_OPERAND, 8'hA5);
    wr(OFF_STATUS, 8'h55);
    apb_host_model_i.xfer(1'b1, OFF_CMD, 32'h01, 1'b1, q, e);
    apb_host_model_i.xfer(1'b1, OFF_OPERAND, 32'h77, 1'b0, q, e);
    check(e, 1);
    repeat (4) @(posedge clk);
    rd(OFF_OPERAND, 8'h3C);
    rd(OFF_MEM_DATA, 8'h99);
    rd(OFF_STATUS, 8'h55);
    rd(OFF_EXEC_STAT, 3);
  endtask
  // Every shift for two operands and both carry values.
  task automatic t_shift();
    for (int op = 2; op < 8; op++)
      for (int i = 0; i < 4; i++)
      begin
        x = shx(op, i[1] ? 8'h80 : 8'h96, {7'h70, i[0]});
        wr(OFF_OPERAND, i[1] ? 8'h80 : 8'h96);
        wr(OFF_STATUS, {7'h70, i[0]});
        cmd(op, 0);
        rd(OFF_OPERAND, x[15:8]);
        rd(OFF_STATUS, x[7:0]);
      end
  endtask
  task automatic t_bits();
    wr(OFF_IO_ADDR, 3);
    wr(OFF_IO_DATA, 8'h0F);
    wr(OFF_STATUS, 8'h1A);
    cmd(5'h08, 7);
    rd(OFF_IO_DATA, 8'h8F);
    cmd(5'h09, 0);
    rd(OFF_IO_DATA, 8'h8E);
    wr(OFF_OPERAND, 8'h80);
    cmd(5'h0A, 7);
    rd(OFF_STATUS, 8'h5A);
    wr(OFF_OPERAND, 8'h00);
    cmd(5'h0B, 0);
    rd(OFF_OPERAND, 8'h01);
    cmd(5'h0A, 1);
    rd(OFF_STATUS, 8'h1A);
  endtask
  // Named flag ops first, then the indexed pair on every flag.
  task automatic t_flags();
    for (int k = 0; k < 22; k++)
    begin
      x[4:0] = (k < 6) ? 14 + k : 12 + k % 2;
      idx = (k < 2) ? FLAG_V : (k < 4) ? FLAG_H : (k < 6) ? FLAG_S
        : (k - 6) / 2;
      x[15:8] = x[0] ? 8'hFF : 8'h00;
      wr(OFF_STATUS, x[15:8]);
      cmd(x[4:0], idx);
      x[7:0] = x[15:8] ^ (8'h01 << idx);
      // Each pair of named ops guards its own flag; the rest are indexed.
      case (k / 2)
        0:       rd(OFF_STATUS, x[7:0]);
        1:       rd(OFF_STATUS, x[7:0]);
        2:       rd(OFF_STATUS, x[7:0]);
        default: rd(OFF_STATUS, x[7:0]);
      endcase
    end
  endtask
  // Control ops and an unknown code: busy for one cycle, then the
  // matching pulse for one cycle, and the flags are left alone.
  // Outputs are looked at mid-cycle, where they are settled.
  task automatic t_ctrl();
    for (int k = 0; k < 5; k++)
    begin
      wr(OFF_STATUS, 8'hC3);
      x[4:0] = (k == 0) ? 5'h00 : 5'(19 + k);
      wr(OFF_CMD, {27'h0, x[4:0]});
      @(negedge clk);
      check({busy, brk, slp, wdc}, 4'h8);
      @(negedge clk);
      check({busy, brk, slp, wdc}, {1'b0, k == 1, k == 2, k == 3});
      @(negedge clk);
      check({brk, slp, wdc}, 3'h0);
      rd(OFF_STATUS, 8'hC3);
      rd(OFF_EXEC_STAT, 1);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang is cut short well past the expected thousand or so cycles.
  initial
  begin
    #2000000;
    err_count++;
    print_verdict();
  end
  initial
  begin
    err_count = 0;
    checks = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_toggle();
    t_shift();
    t_bits();
    t_flags();
    t_ctrl();
    print_verdict();
  end
endmodule // bit_flag_shift_ops_test
`default_nettype wire
